// File: rtl/dsrd_pkg.sv
// package: register map, field positions, reset values and formats of the speed decoder
package dsrd_pkg;

   // register byte offsets (word aligned)
   localparam logic [7:0] DSRD_ADDR_CONST_ONE = 8'h00;
   localparam logic [7:0] DSRD_ADDR_CONST_TWO = 8'h04;
   localparam logic [7:0] DSRD_ADDR_RATED   = 8'h08;
   localparam logic [7:0] DSRD_ADDR_STATUS  = 8'h0C;
   localparam logic [2:0] DSRD_PRESET_PAGE  = 3'h1;    // presets at 0x20..0x3C

   // field positions
   localparam int         DSRD_LINES_OFF_BIT  = 7;     // set: lines are not the reference
   localparam int         DSRD_FMT_SEL_HI     = 7;
   localparam int         DSRD_FMT_SEL_LO     = 6;
   localparam int         DSRD_STAT_MODE_LSB  = 16;
   localparam int         DSRD_STAT_ANALOG    = 20;
   localparam int         DSRD_STAT_OPER      = 21;
   localparam int         DSRD_STAT_DIGITAL   = 22;

   // reset values
   localparam logic [7:0]  DSRD_CONST_ONE_RESET = 8'h00;
   localparam logic [7:0]  DSRD_CONST_TWO_RESET = 8'h40;  // format bits 01: binary
   localparam logic [15:0] DSRD_RATED_RESET  = 16'h1770;
   localparam logic [13:0] DSRD_PRESET_RESET = 14'h0000;

   // full-scale values of each format
   localparam logic [13:0] DSRD_FS_BINARY = 14'h0FFF;
   localparam logic [13:0] DSRD_FS_BCD3   = 14'h03E7;
   localparam logic [13:0] DSRD_FS_BCD2   = 14'h0063;
   localparam logic [13:0] DSRD_FS_PRESET = 14'h2710;  // 100.00 in hundredths

   localparam int          DSRD_NUM_PRESETS = 8;

   // bus responses
   localparam logic [1:0]  DSRD_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  DSRD_RESP_SLVERR = 2'h2;

   // format select, in the order of the two selection bits
   typedef enum logic [1:0] {
      DSRD_FMT_BCD2,
      DSRD_FMT_BINARY,
      DSRD_FMT_BCD3,
      DSRD_FMT_PRESET
   } dsrd_fmt_t;

endpackage : dsrd_pkg

// File: rtl/dsrd_prio.sv
// lowest-index-wins priority encoder for the preset select lines
`timescale 1ns/10ps
module dsrd_prio #(
   parameter int N = 8,
   parameter int W = 3
) (
   // select lines, bit 0 has top priority
   input  wire logic [N-1:0] lines,
   // encoded result
   output logic      [W-1:0] idx,
   output logic              any
);

   // scan downward so the lowest active line is written last
   always_comb begin
      idx = '0;
      any = 1'b0;
      for (int i = N - 1; i >= 0; i--) begin
         if (lines[i]) begin
            idx = W'(i);
            any = 1'b1;
         end
      end
   end

endmodule : dsrd_prio

// File: rtl/dsrd_top.sv
// digital speed reference decoder with its AXI4-Lite register slave
//
// Contract
// - lines are the reference only if bit 7 clear
// - select on: format by bits 7:6; off: analog
// - format resets to 12-bit binary
// - select input changes ignored while operating
// - direction only from forward and reverse inputs
// - eight presets, percent of rated, lines 1-8
// - several preset lines: lowest number wins
// - no preset line active gives zero speed
// - preset writes refused while operating
// - binary line n weighs two to n-1
// - all twelve lines map to rated speed
// - three BCD digits, 999 maps to rated
// - two BCD digits on lines 5-12, 99 rated
// - select off analog, on digital reference
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module dsrd_top
   import dsrd_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // parallel reference and sequence inputs
   input  wire logic [11:0] parallel_speed_lines,
   input  wire logic        analog_digital_select,
   input  wire logic        run_forward,
   input  wire logic        run_reverse,
   // decoded command
   output logic      [15:0] speed_command_q,
   output logic             digital_active_q,
   output logic             use_analog_q,
   output logic             direction_forward_q,
   output logic             direction_reverse_q,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready_q,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready_q,
   // axi4-lite write response
   output logic      [1:0]  s_axi_bresp_q,
   output logic             s_axi_bvalid_q,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready_q,
   // axi4-lite read data
   output logic      [31:0] s_axi_rdata_q,
   output logic      [1:0]  s_axi_rresp_q,
   output logic             s_axi_rvalid_q,
   input  wire logic        s_axi_rready
);

   // configuration state
   logic [7:0]  const_one_q, const_one_d;
   logic [7:0]  const_two_q, const_two_d;
   logic [15:0] rated_q, rated_d;
   logic [13:0] preset_q [DSRD_NUM_PRESETS];
   logic [13:0] preset_d [DSRD_NUM_PRESETS];
   // sampled inputs
   logic [11:0] lines_q;
   logic        forward_q, reverse_q, select_q, select_d;
   // bus state
   logic [7:0]  awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d;
   logic [3:0]  wstrb_q, wstrb_d;
   logic        awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
   logic [1:0]  bresp_d, rresp_d;
   logic [31:0] rdata_d;
   // decode results
   logic        operating, digital_en, do_write, prio_any;
   logic [2:0]  prio_idx;
   dsrd_fmt_t   fmt;
   logic [13:0] raw_val, clamp_val, fs_val;
   logic [29:0] product;
   logic [15:0] scaled, speed_d;

   // byte-lane merge of a write into the old word
   function automatic logic [31:0] dsrd_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  strb);
      logic [31:0] res;
      res = old_w;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_w[8*b +: 8];
         end
      end
      return res;
   endfunction : dsrd_merge

   // drive counts as operating while either run input is on
   assign operating  = forward_q | reverse_q;
   assign digital_en = select_q & ~const_one_q[DSRD_LINES_OFF_BIT];
   assign fmt        = dsrd_fmt_t'(const_two_q[DSRD_FMT_SEL_HI:DSRD_FMT_SEL_LO]);
   assign do_write   = ~s_axi_awready_q & ~s_axi_wready_q & ~s_axi_bvalid_q;

   // preset selection on the first eight lines
   dsrd_prio #(
      .N (DSRD_NUM_PRESETS),
      .W (3)
   ) u_prio (
      .lines (lines_q[7:0]),
      .idx   (prio_idx),
      .any   (prio_any)
   );

   // word as software sees it; unmapped reads zero
   function automatic logic [31:0] dsrd_word(input logic [7:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (a[7:5] == DSRD_PRESET_PAGE) begin
         w[13:0] = preset_q[a[4:2]];
      end else begin
         unique case ({a[7:2], 2'b00})
            DSRD_ADDR_CONST_ONE: w[7:0] = const_one_q;
            DSRD_ADDR_CONST_TWO: w[7:0] = const_two_q;
            DSRD_ADDR_RATED:  w[15:0] = rated_q;
            DSRD_ADDR_STATUS: begin
               w[15:0]                       = speed_command_q;
               w[DSRD_STAT_MODE_LSB +: 2]    = fmt;
               w[DSRD_STAT_ANALOG]           = use_analog_q;
               w[DSRD_STAT_OPER]             = operating;
               w[DSRD_STAT_DIGITAL]          = digital_active_q;
            end
            default:          w = 32'h0000_0000;
         endcase
      end
      return w;
   endfunction : dsrd_word

   // raw value and full scale of the active format
   always_comb begin
      raw_val = 14'h0000;
      fs_val  = DSRD_FS_BINARY;
      unique case (fmt)
         DSRD_FMT_BINARY: begin
            raw_val = {2'b00, lines_q};
            fs_val  = DSRD_FS_BINARY;
         end
         DSRD_FMT_BCD3: begin
            raw_val = 14'(lines_q[3:0]) + 14'(lines_q[7:4]) * 14'h000A
                    + 14'(lines_q[11:8]) * 14'h0064;
            fs_val  = DSRD_FS_BCD3;
         end
         DSRD_FMT_BCD2: begin
            raw_val = 14'(lines_q[7:4]) + 14'(lines_q[11:8]) * 14'h000A;
            fs_val  = DSRD_FS_BCD2;
         end
         DSRD_FMT_PRESET: begin
            raw_val = prio_any ? preset_q[prio_idx] : 14'h0000;
            fs_val  = DSRD_FS_PRESET;
         end
      endcase
   end

   // scale to rated speed; values above full scale clamp at full scale, never beyond rated
   always_comb begin
      clamp_val = (raw_val > fs_val) ? fs_val : raw_val;
      product   = 30'(rated_q) * 30'(clamp_val);
      scaled    = 16'(product / 30'(fs_val));
      speed_d   = digital_en ? scaled : 16'h0000;
      select_d  = operating ? select_q : analog_digital_select;
   end

   // input sampling and command outputs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lines_q             <= 12'h000;
         forward_q           <= 1'b0;
         reverse_q           <= 1'b0;
         select_q            <= 1'b0;
         speed_command_q     <= 16'h0000;
         digital_active_q    <= 1'b0;
         use_analog_q        <= 1'b1;
         direction_forward_q <= 1'b0;
         direction_reverse_q <= 1'b0;
      end else begin
         lines_q             <= parallel_speed_lines;
         forward_q           <= run_forward;
         reverse_q           <= run_reverse;
         select_q            <= select_d;
         speed_command_q     <= speed_d;
         digital_active_q    <= digital_en;
         use_analog_q        <= ~select_q;
         direction_forward_q <= forward_q;
         direction_reverse_q <= reverse_q;
      end
   end

   // bus handshakes and register writes
   always_comb begin
      logic [31:0] merged;
      merged    = dsrd_merge(dsrd_word(awaddr_q), wdata_q, wstrb_q);
      const_one_d = const_one_q;
      const_two_d = const_two_q;
      rated_d   = rated_q;
      preset_d  = preset_q;
      awaddr_d  = awaddr_q;
      wdata_d   = wdata_q;
      wstrb_d   = wstrb_q;
      awready_d = s_axi_awready_q;
      wready_d  = s_axi_wready_q;
      bvalid_d  = s_axi_bvalid_q;
      bresp_d   = s_axi_bresp_q;
      arready_d = s_axi_arready_q;
      rvalid_d  = s_axi_rvalid_q;
      rresp_d   = s_axi_rresp_q;
      rdata_d   = s_axi_rdata_q;
      if (s_axi_awvalid && s_axi_awready_q) begin
         awaddr_d  = s_axi_awaddr;
         awready_d = 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready_q) begin
         wdata_d  = s_axi_wdata;
         wstrb_d  = s_axi_wstrb;
         wready_d = 1'b0;
      end
      if (do_write) begin
         bvalid_d = 1'b1;
         bresp_d  = DSRD_RESP_OKAY;
         if (awaddr_q[7:5] == DSRD_PRESET_PAGE) begin
            // refused writes leave the stored percentage untouched
            if (operating || merged[13:0] > DSRD_FS_PRESET || merged[31:14] != '0) begin
               bresp_d = DSRD_RESP_SLVERR;
            end else begin
               preset_d[awaddr_q[4:2]] = merged[13:0];
            end
         end else begin
            unique case ({awaddr_q[7:2], 2'b00})
               DSRD_ADDR_CONST_ONE: const_one_d = merged[7:0];
               DSRD_ADDR_CONST_TWO: const_two_d = merged[7:0];
               DSRD_ADDR_RATED: rated_d = merged[15:0];
               default:         bresp_d = DSRD_RESP_SLVERR;
            endcase
         end
      end
      if (s_axi_bvalid_q && s_axi_bready) begin
         bvalid_d  = 1'b0;
         awready_d = 1'b1;
         wready_d  = 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready_q) begin
         arready_d = 1'b0;
         rvalid_d  = 1'b1;
         rdata_d   = dsrd_word(s_axi_araddr);
         // judged on the word address, so a byte offset inside a mapped word is no error
         rresp_d   = ({s_axi_araddr[7:2], 2'b00} > DSRD_ADDR_STATUS
                      && s_axi_araddr[7:5] != DSRD_PRESET_PAGE)
                     ? DSRD_RESP_SLVERR : DSRD_RESP_OKAY;
      end
      if (s_axi_rvalid_q && s_axi_rready) begin
         rvalid_d  = 1'b0;
         arready_d = 1'b1;
      end
   end

   // register file and bus flops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         const_one_q     <= DSRD_CONST_ONE_RESET;
         const_two_q     <= DSRD_CONST_TWO_RESET;
         rated_q         <= DSRD_RATED_RESET;
         for (int i = 0; i < DSRD_NUM_PRESETS; i++) begin
            preset_q[i] <= DSRD_PRESET_RESET;
         end
         awaddr_q        <= 8'h00;
         wdata_q         <= 32'h0000_0000;
         wstrb_q         <= 4'h0;
         s_axi_awready_q <= 1'b1;
         s_axi_wready_q  <= 1'b1;
         s_axi_bvalid_q  <= 1'b0;
         s_axi_bresp_q   <= DSRD_RESP_OKAY;
         s_axi_arready_q <= 1'b1;
         s_axi_rvalid_q  <= 1'b0;
         s_axi_rresp_q   <= DSRD_RESP_OKAY;
         s_axi_rdata_q   <= 32'h0000_0000;
      end else begin
         const_one_q     <= const_one_d;
         const_two_q     <= const_two_d;
         rated_q         <= rated_d;
         preset_q        <= preset_d;
         awaddr_q        <= awaddr_d;
         wdata_q         <= wdata_d;
         wstrb_q         <= wstrb_d;
         s_axi_awready_q <= awready_d;
         s_axi_wready_q  <= wready_d;
         s_axi_bvalid_q  <= bvalid_d;
         s_axi_bresp_q   <= bresp_d;
         s_axi_arready_q <= arready_d;
         s_axi_rvalid_q  <= rvalid_d;
         s_axi_rresp_q   <= rresp_d;
         s_axi_rdata_q   <= rdata_d;
      end
   end

   // checks on the decode path
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // helper: no write has reached the format register yet
   logic const_two_written_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         const_two_written_q <= 1'b0;
      end else if (do_write && {awaddr_q[7:2], 2'b00} == DSRD_ADDR_CONST_TWO) begin
         const_two_written_q <= 1'b1;
      end
   end

   sequence s_full_in(dsrd_fmt_t f, logic hit);
      digital_en && fmt == f && hit && $stable(rated_q);
   endsequence

   sequence s_preset_write_busy;
      do_write && awaddr_q[7:5] == DSRD_PRESET_PAGE && operating;
   endsequence

   lines_off_a:     assert property (const_one_q[DSRD_LINES_OFF_BIT] |=> speed_command_q == 16'h0000)
                       else $error("speed nonzero with lines deselected");
   analog_sel_a:    assert property (!select_q |=> use_analog_q && !digital_active_q)
                       else $error("analog path not chosen");
   factory_fmt_a:   assert property (!const_two_written_q |-> fmt == DSRD_FMT_BINARY)
                       else $error("format not binary after reset");
   das_freeze_a:    assert property (operating ##1 operating |-> $stable(select_q))
                       else $error("select changed during operation");
   dir_follow_a:    assert property ((run_forward && !run_reverse) ##1 1'b1
                                     |=> direction_forward_q && !direction_reverse_q)
                       else $error("direction not from run inputs");
   binary_full_a:   assert property (s_full_in(DSRD_FMT_BINARY, lines_q == 12'hFFF)
                                     |=> speed_command_q == $past(rated_q))
                       else $error("binary full scale not rated");
   bcd3_full_a:     assert property (s_full_in(DSRD_FMT_BCD3, lines_q == 12'h999)
                                     |=> speed_command_q == $past(rated_q))
                       else $error("999 not rated speed");
   bcd2_full_a:     assert property (s_full_in(DSRD_FMT_BCD2, lines_q[11:4] == 8'h99)
                                     |=> speed_command_q == $past(rated_q))
                       else $error("99 not rated speed");
   preset_prio_a:   assert property (lines_q[1:0] == 2'b10 |-> prio_any && prio_idx == 3'h1)
                       else $error("preset priority wrong");
   preset_none_a:   assert property (digital_en && fmt == DSRD_FMT_PRESET && lines_q[7:0] == 8'h00
                                     |=> speed_command_q == 16'h0000)
                       else $error("no preset line but speed nonzero");
   preset_lock_a:   assert property (s_preset_write_busy |=> s_axi_bvalid_q
                                     && s_axi_bresp_q == DSRD_RESP_SLVERR)
                       else $error("preset write accepted while running");
   sample_word_a:   assert property (##1 lines_q == $past(parallel_speed_lines))
                       else $error("lines not sampled together");

endmodule : dsrd_top

// File: test/dsrd_host_model.sv
// host sequencer model: drives the parallel reference, select and run lines
`timescale 1ns/10ps
module dsrd_host_model (
   // clock
   input  wire logic        clk,
   // lines toward the decoder
   output logic      [11:0] parallel_speed_lines,
   output logic             analog_digital_select,
   output logic             run_forward,
   output logic             run_reverse
);
   // relay outputs rest open (low) until the bench commands them
   initial begin
      parallel_speed_lines  = 12'h000;
      analog_digital_select = 1'b0;
      run_forward           = 1'b0;
      run_reverse           = 1'b0;
   end

   // the whole word moves on one edge, never line by line
   task automatic put_lines(input logic [11:0] v);
      @(posedge clk);
      parallel_speed_lines <= v;
   endtask : put_lines

   task automatic put_run(input logic f, input logic r);
      @(posedge clk);
      run_forward <= f;
      run_reverse <= r;
   endtask : put_run

   // insist lets a scenario break the stopped-only habit on purpose
   task automatic put_select(input logic v, input logic insist);
      @(posedge clk);
      if (insist || !(run_forward || run_reverse)) begin
         analog_digital_select <= v;
      end
   endtask : put_select
endmodule : dsrd_host_model

// File: test/dsrd_top_tb.sv
// self-checking bench for the speed reference decoder
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module dsrd_top_tb
   import dsrd_pkg::*;
;
   localparam logic [31:0] RATED = 32'h0000_0FA0;  // 4000, a multiple of no full scale, so truncation shows

   logic        clk, resetn;
   logic [11:0] parallel_speed_lines;
   logic        analog_digital_select, run_forward, run_reverse;
   logic [15:0] speed_command_q;
   logic        digital_active_q, use_analog_q, direction_forward_q, direction_reverse_q;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata_q, rd;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_awvalid, s_axi_awready_q, s_axi_wvalid, s_axi_wready_q;
   logic [1:0]  s_axi_bresp_q, s_axi_rresp_q, rr;
   logic        s_axi_bvalid_q, s_axi_bready, s_axi_arvalid, s_axi_arready_q;
   logic        s_axi_rvalid_q, s_axi_rready;
   int          error_cnt, n_compared;

   dsrd_host_model host (.clk(clk), .parallel_speed_lines(parallel_speed_lines),
      .analog_digital_select(analog_digital_select), .run_forward(run_forward),
      .run_reverse(run_reverse));

   dsrd_top uut (.clk(clk), .resetn(resetn), .parallel_speed_lines(parallel_speed_lines),
      .analog_digital_select(analog_digital_select), .run_forward(run_forward),
      .run_reverse(run_reverse), .speed_command_q(speed_command_q),
      .digital_active_q(digital_active_q), .use_analog_q(use_analog_q),
      .direction_forward_q(direction_forward_q), .direction_reverse_q(direction_reverse_q),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready_q(s_axi_awready_q), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready_q(s_axi_wready_q), .s_axi_bresp_q(s_axi_bresp_q),
      .s_axi_bvalid_q(s_axi_bvalid_q), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready_q(s_axi_arready_q), .s_axi_rdata_q(s_axi_rdata_q),
      .s_axi_rresp_q(s_axi_rresp_q), .s_axi_rvalid_q(s_axi_rvalid_q),
      .s_axi_rready(s_axi_rready));

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      tally_and_finish();
   end

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish

   // expected speed: rated scaled by the clamped value over full scale
   function automatic logic [15:0] exp_spd(input logic [31:0] v, input logic [31:0] fs);
      logic [31:0] c;
      c = (v > fs) ? fs : v;
      return 16'((RATED * c) / fs);
   endfunction : exp_spd

   task automatic settle();
      repeat (4) @(posedge clk);
   endtask : settle

   // write: address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic       done;
      logic [1:0] r;
      done = 1'b0;
      r    = 2'h3;
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!done) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready_q) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready_q) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid_q && s_axi_bready) begin
            r = s_axi_bresp_q;
            done = 1'b1;
            s_axi_bready <= 1'b0;
         end
      end
      `CHK("bresp", er, r)
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!done) begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready_q) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid_q && s_axi_rready) begin
            d = s_axi_rdata_q;
            r = s_axi_rresp_q;
            done = 1'b1;
            s_axi_rready <= 1'b0;
         end
      end
   endtask : axi_rd

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      axi_rd(a, rd, rr);
      `CHK("rdata", ed, rd)
      `CHK("rresp", er, rr)
   endtask : rd_chk

   task automatic lines_chk(input logic [11:0] ln, input logic [31:0] v, input logic [31:0] fs);
      host.put_lines(ln);
      settle();
      `CHK("speed", exp_spd(v, fs), speed_command_q)
   endtask : lines_chk

   initial begin
      resetn = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      error_cnt = 0;
      n_compared = 0;
      repeat (12) @(posedge clk);
      `CHK("analog_rst", 1'b1, use_analog_q)
      resetn <= 1'b1;
      rd_chk(DSRD_ADDR_CONST_ONE, 32'h0000_0000, DSRD_RESP_OKAY);
      rd_chk(DSRD_ADDR_CONST_TWO, 32'h0000_0040, DSRD_RESP_OKAY);
      axi_wr(DSRD_ADDR_RATED, RATED, DSRD_RESP_OKAY);
      // one byte lane only: the upper lane must keep the stored rated value
      @(posedge clk);
      s_axi_wstrb <= 4'h1;
      axi_wr(DSRD_ADDR_RATED, 32'h0000_0055, DSRD_RESP_OKAY);
      rd_chk(DSRD_ADDR_RATED, 32'h0000_0F55, DSRD_RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      axi_wr(DSRD_ADDR_RATED, RATED, DSRD_RESP_OKAY);
      host.put_lines(12'hFFF);
      settle();
      `CHK("speed_analog", 16'h0000, speed_command_q)
      host.put_select(1'b1, 1'b0);
      settle();
      `CHK("analog", 1'b0, use_analog_q)
      `CHK("digital", 1'b1, digital_active_q)
      lines_chk(12'hFFF, DSRD_FS_BINARY, DSRD_FS_BINARY);
      for (int n = 0; n < 12; n++) begin
         lines_chk(12'(1 << n), 32'(1 << n), DSRD_FS_BINARY);
      end
      // a full swing must never show a half-updated word
      host.put_lines(12'h000);
      settle();
      host.put_lines(12'hFFF);
      repeat (6) begin
         @(posedge clk);
         `CHK("word", 1'b1, (speed_command_q === 16'h0000) || (speed_command_q === 16'h0FA0))
      end
      axi_wr(DSRD_ADDR_CONST_ONE, 32'h0000_0080, DSRD_RESP_OKAY);
      settle();
      `CHK("digital_off", 1'b0, digital_active_q)
      `CHK("speed_off", 16'h0000, speed_command_q)
      axi_wr(DSRD_ADDR_CONST_ONE, 32'h0000_0000, DSRD_RESP_OKAY);
      axi_wr(DSRD_ADDR_CONST_TWO, 32'h0000_0080, DSRD_RESP_OKAY);
      lines_chk(12'h999, 32'h3E7, DSRD_FS_BCD3);
      lines_chk(12'h800, 32'h320, DSRD_FS_BCD3);
      lines_chk(12'h123, 32'h7B, DSRD_FS_BCD3);
      axi_wr(DSRD_ADDR_CONST_TWO, 32'h0000_0000, DSRD_RESP_OKAY);
      lines_chk(12'h99F, 32'h63, DSRD_FS_BCD2);
      lines_chk(12'h45A, 32'h2D, DSRD_FS_BCD2);
      axi_wr(DSRD_ADDR_CONST_TWO, 32'h0000_00C0, DSRD_RESP_OKAY);
      for (int k = 0; k < 8; k++) begin
         axi_wr(8'(8'h20 + 4 * k), 32'(32'h4E2 * (k + 1)), DSRD_RESP_OKAY);
      end
      axi_wr(8'h20, 32'h2711, DSRD_RESP_SLVERR);
      for (int k = 0; k < 8; k++) begin
         lines_chk(12'(1 << k), 32'(32'h4E2 * (k + 1)), DSRD_FS_PRESET);
      end
      lines_chk(12'h012, 32'h9C4, DSRD_FS_PRESET);
      lines_chk(12'hF00, 32'h0, DSRD_FS_PRESET);
      lines_chk(12'h001, 32'h4E2, DSRD_FS_PRESET);
      host.put_run(1'b1, 1'b0);
      settle();
      `CHK("dir_fwd", 2'b10, {direction_forward_q, direction_reverse_q})
      `CHK("speed_run", exp_spd(32'h4E2, DSRD_FS_PRESET), speed_command_q)
      axi_wr(8'h20, 32'h0000_0005, DSRD_RESP_SLVERR);
      rd_chk(8'h20, 32'h0000_04E2, DSRD_RESP_OKAY);
      axi_rd(DSRD_ADDR_STATUS, rd, rr);
      `CHK("stat_oper", 1'b1, rd[DSRD_STAT_OPER])
      `CHK("stat_fmt", 2'b11, rd[DSRD_STAT_MODE_LSB +: 2])
      host.put_select(1'b0, 1'b1);
      host.put_run(1'b0, 1'b1);
      settle();
      `CHK("analog_run", 1'b0, use_analog_q)
      `CHK("dir_rev", 2'b01, {direction_forward_q, direction_reverse_q})
      host.put_run(1'b0, 1'b0);
      settle();
      `CHK("analog_stop", 1'b1, use_analog_q)
      `CHK("speed_stop", 16'h0000, speed_command_q)
      rd_chk(8'h40, 32'h0000_0000, DSRD_RESP_SLVERR);
      axi_wr(DSRD_ADDR_STATUS, 32'h0000_0001, DSRD_RESP_SLVERR);
      tally_and_finish();
   end
endmodule : dsrd_top_tb
